// file: inc/bth_pkg.sv
// Types shared by the bridge header register bank
package bth_pkg;

    typedef logic [5:0] bth_idx_t;
    typedef logic [7:0] bth_byte_t;

    typedef enum logic [1:0] {
        BTH_WR_IDLE = 2'b01,
        BTH_WR_RESP = 2'b10
    } bth_wr_state_e;

    typedef enum logic [1:0] {
        BTH_RD_IDLE = 2'b01,
        BTH_RD_DATA = 2'b10
    } bth_rd_state_e;

endpackage

// file: inc/bth_regs.svh
// Offsets, field positions, reset and fixed values of the bridge header bank
`ifndef BTH_REGS_SVH
`define BTH_REGS_SVH

// Register indices; the byte address is four times the index
`define BTH_IDX_CLASS      6'h09
`define BTH_IDX_LINE_SZ    6'h0C
`define BTH_IDX_UP_LAT     6'h0D
`define BTH_IDX_LAYOUT     6'h0E
`define BTH_IDX_SELFTEST   6'h0F
`define BTH_IDX_WIN0       6'h10
`define BTH_IDX_WIN1       6'h14
`define BTH_IDX_UP_BUS     6'h18
`define BTH_IDX_DN_BUS     6'h19
`define BTH_IDX_HI_BUS     6'h1A
`define BTH_IDX_DN_LAT     6'h1B
`define BTH_IDX_IO_LOW     6'h1C
`define BTH_IDX_IO_HIGH    6'h1D

// Index position inside the byte address
`define BTH_IDX_LSB        2
`define BTH_IDX_MSB        7

// Fixed read-only values
`define BTH_CLASS_CODE     24'h06_0400
`define BTH_LAYOUT_TYPE    8'h01
`define BTH_ZERO8          8'h00
`define BTH_ZERO32         32'h0000_0000

// Reset values of stored state, including the fixed I/O width bit
`define BTH_LINE_SZ_RST    8'h00
`define BTH_BUS_RST        8'h00
`define BTH_IO_CAP_RST     1'b1
`define BTH_IO_BASE_RST    4'hF
`define BTH_IO_LIMIT_RST   4'h0

// I/O window field positions and address fill
`define BTH_IO_CAP_BIT     0
`define BTH_IO_FLD_LSB     4
`define BTH_IO_FLD_MSB     7
`define BTH_IO_LOW_FILL    12'h000
`define BTH_IO_HIGH_FILL   12'hFFF
`define BTH_IO_UPPER_ZERO  16'h0000

// Bus response codes
`define BTH_RESP_OKAY      2'b00
`define BTH_RESP_SLVERR    2'b10

`endif

// file: rtl/bth_cfg_regs.sv
// Bridge type 1 header register bank with AXI4-Lite slave and I/O decode
//
// Operation
// - Class code reads fixed bridge value
// - Cache line size is plain storage
// - Upstream latency timer reads zero
// - Header type reads one
// - Self-test byte reads zero
// - Both address windows read zero
// - Upstream bus number is plain storage
// - Downstream bus number is read/write
// - Highest behind bus number is read/write
// - Downstream latency timer reads zero
// - Bit zero reports 32-bit I/O width
// - I/O base field, read/write, resets 0xF
// - Base and limit steer I/O forwarding
// - Limit capability bit mirrors base bit
// - Limit field fills low bits ones
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "bth_regs.svh"

module bth_cfg_regs
    import bth_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        io_req_valid,
    input  wire logic [31:0] io_req_addr,
    output logic             io_fwd_valid,
    output logic             io_fwd_hit
);

    // Index decode shared by the write and the read path
    function automatic logic reg_mapped(input bth_idx_t idx);
        case (idx)
            `BTH_IDX_CLASS,
            `BTH_IDX_LINE_SZ,
            `BTH_IDX_UP_LAT,
            `BTH_IDX_LAYOUT,
            `BTH_IDX_SELFTEST,
            `BTH_IDX_WIN0,
            `BTH_IDX_WIN1,
            `BTH_IDX_UP_BUS,
            `BTH_IDX_DN_BUS,
            `BTH_IDX_HI_BUS,
            `BTH_IDX_DN_LAT,
            `BTH_IDX_IO_LOW,
            `BTH_IDX_IO_HIGH: reg_mapped = 1'b1;
            default:          reg_mapped = 1'b0;
        endcase
    endfunction

    bth_wr_state_e wr_state_r;
    bth_wr_state_e wr_state_nxt;
    bth_rd_state_e rd_state_r;
    bth_rd_state_e rd_state_nxt;

    logic          awready_r;
    logic          wready_r;
    logic          bvalid_r;
    logic [1:0]    bresp_r;
    logic          arready_r;
    logic          rvalid_r;
    logic [31:0]   rdata_r;
    logic [1:0]    rresp_r;

    logic          aw_held_r;
    logic          aw_held_nxt;
    bth_idx_t      aw_idx_r;
    logic          w_held_r;
    logic          w_held_nxt;
    logic [31:0]   w_data_r;
    logic          w_lane0_r;

    bth_byte_t     line_size_r;
    bth_byte_t     up_bus_r;
    bth_byte_t     dn_bus_r;
    bth_byte_t     hi_bus_r;
    logic          io_cap_r;
    logic [3:0]    io_base_r;
    logic [3:0]    io_limit_r;

    logic          fwd_valid_r;
    logic          fwd_hit_r;

    logic          aw_take;
    logic          w_take;
    logic          wr_fire;
    logic          b_done;
    logic          ar_take;
    logic          r_done;
    logic          wr_lane0;
    bth_idx_t      ar_idx;
    logic [31:0]   rd_word;
    logic [15:0]   io_lo_addr;
    logic [15:0]   io_hi_addr;
    logic          io_in_window;

    // Channel handshakes
    assign aw_take  = s_axi_awvalid & awready_r;
    assign w_take   = s_axi_wvalid & wready_r;
    assign wr_fire  = (wr_state_r == BTH_WR_IDLE) & aw_held_r & w_held_r;
    assign b_done   = bvalid_r & s_axi_bready;
    assign ar_take  = s_axi_arvalid & arready_r;
    assign r_done   = rvalid_r & s_axi_rready;
    assign wr_lane0 = wr_fire & w_lane0_r & reg_mapped(aw_idx_r);
    assign ar_idx   = s_axi_araddr[`BTH_IDX_MSB:`BTH_IDX_LSB];

    // Write address and data are held until the response is taken
    assign aw_held_nxt = (aw_held_r | aw_take) & ~b_done;
    assign w_held_nxt  = (w_held_r | w_take) & ~b_done;

    // Write sequence: collect both halves, then answer
    always_comb begin
        wr_state_nxt = wr_state_r;
        case (wr_state_r)
            BTH_WR_IDLE: begin
                if (wr_fire) begin
                    wr_state_nxt = BTH_WR_RESP;
                end
            end
            BTH_WR_RESP: begin
                if (b_done) begin
                    wr_state_nxt = BTH_WR_IDLE;
                end
            end
            default: wr_state_nxt = BTH_WR_IDLE;
        endcase
    end

    // Read sequence: one outstanding read
    always_comb begin
        rd_state_nxt = rd_state_r;
        case (rd_state_r)
            BTH_RD_IDLE: begin
                if (ar_take) begin
                    rd_state_nxt = BTH_RD_DATA;
                end
            end
            BTH_RD_DATA: begin
                if (r_done) begin
                    rd_state_nxt = BTH_RD_IDLE;
                end
            end
            default: rd_state_nxt = BTH_RD_IDLE;
        endcase
    end

    // Write channel state and ready flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= BTH_WR_IDLE;
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            awready_r  <= 1'b0;
            wready_r   <= 1'b0;
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_held_r  <= aw_held_nxt;
            w_held_r   <= w_held_nxt;
            awready_r  <= (wr_state_nxt == BTH_WR_IDLE) & ~aw_held_nxt;
            wready_r   <= (wr_state_nxt == BTH_WR_IDLE) & ~w_held_nxt;
        end
    end

    // Captured write address and data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx_r  <= 6'h00;
            w_data_r  <= `BTH_ZERO32;
            w_lane0_r <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_idx_r <= s_axi_awaddr[`BTH_IDX_MSB:`BTH_IDX_LSB];
            end
            if (w_take) begin
                w_data_r  <= s_axi_wdata;
                w_lane0_r <= s_axi_wstrb[0];
            end
        end
    end

    // Write response, error for an unmapped index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `BTH_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= reg_mapped(aw_idx_r) ? `BTH_RESP_OKAY
                                             : `BTH_RESP_SLVERR;
        end else if (b_done) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_size_r <= `BTH_LINE_SZ_RST;
        end else if (wr_lane0 && aw_idx_r == `BTH_IDX_LINE_SZ) begin
            line_size_r <= w_data_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_bus_r <= `BTH_BUS_RST;
            dn_bus_r <= `BTH_BUS_RST;
            hi_bus_r <= `BTH_BUS_RST;
        end else if (wr_lane0) begin
            if (aw_idx_r == `BTH_IDX_UP_BUS) begin
                up_bus_r <= w_data_r[7:0];
            end
            if (aw_idx_r == `BTH_IDX_DN_BUS) begin
                dn_bus_r <= w_data_r[7:0];
            end
            if (aw_idx_r == `BTH_IDX_HI_BUS) begin
                hi_bus_r <= w_data_r[7:0];
            end
        end
    end

    // width bit locked at its reset value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_cap_r <= `BTH_IO_CAP_RST;
        end else begin
            io_cap_r <= io_cap_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_base_r  <= `BTH_IO_BASE_RST;
            io_limit_r <= `BTH_IO_LIMIT_RST;
        end else if (wr_lane0) begin
            if (aw_idx_r == `BTH_IDX_IO_LOW) begin
                io_base_r <= w_data_r[`BTH_IO_FLD_MSB:`BTH_IO_FLD_LSB];
            end
            if (aw_idx_r == `BTH_IDX_IO_HIGH) begin
                io_limit_r <= w_data_r[`BTH_IO_FLD_MSB:`BTH_IO_FLD_LSB];
            end
        end
    end

    always_comb begin
        rd_word = `BTH_ZERO32;
        case (ar_idx)
            `BTH_IDX_CLASS:    rd_word = {`BTH_ZERO8, `BTH_CLASS_CODE};
            `BTH_IDX_LINE_SZ:  rd_word = {24'h00_0000, line_size_r};
            `BTH_IDX_UP_LAT:   rd_word = `BTH_ZERO32;
            `BTH_IDX_LAYOUT:   rd_word = {24'h00_0000, `BTH_LAYOUT_TYPE};
            `BTH_IDX_SELFTEST: rd_word = `BTH_ZERO32;
            `BTH_IDX_WIN0:     rd_word = `BTH_ZERO32;
            `BTH_IDX_WIN1:     rd_word = `BTH_ZERO32;
            `BTH_IDX_UP_BUS:   rd_word = {24'h00_0000, up_bus_r};
            `BTH_IDX_DN_BUS:   rd_word = {24'h00_0000, dn_bus_r};
            `BTH_IDX_HI_BUS:   rd_word = {24'h00_0000, hi_bus_r};
            `BTH_IDX_DN_LAT:   rd_word = `BTH_ZERO32;
            `BTH_IDX_IO_LOW:
                rd_word = {24'h00_0000, io_base_r, 3'b000, io_cap_r};
            `BTH_IDX_IO_HIGH:
                rd_word = {24'h00_0000, io_limit_r, 3'b000, io_cap_r};
            default:           rd_word = `BTH_ZERO32;
        endcase
    end

    // Read channel: data sampled when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= BTH_RD_IDLE;
            arready_r  <= 1'b0;
            rvalid_r   <= 1'b0;
            rdata_r    <= `BTH_ZERO32;
            rresp_r    <= `BTH_RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            arready_r  <= (rd_state_nxt == BTH_RD_IDLE);
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_word;
                rresp_r  <= reg_mapped(ar_idx) ? `BTH_RESP_OKAY
                                               : `BTH_RESP_SLVERR;
            end else if (r_done) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // window bounds, limit filled with ones
    assign io_lo_addr   = {io_base_r, `BTH_IO_LOW_FILL};
    assign io_hi_addr   = {io_limit_r, `BTH_IO_HIGH_FILL};
    assign io_in_window = (io_req_addr[31:16] == `BTH_IO_UPPER_ZERO)
                        & (io_req_addr[15:0] >= io_lo_addr)
                        & (io_req_addr[15:0] <= io_hi_addr);

    // forwarding decision one cycle after the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_valid_r <= 1'b0;
            fwd_hit_r   <= 1'b0;
        end else begin
            fwd_valid_r <= io_req_valid;
            fwd_hit_r   <= io_req_valid & io_in_window;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign io_fwd_valid  = fwd_valid_r;
    assign io_fwd_hit    = fwd_hit_r;

    // Checks on the bank and the bus slave
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_class_code_read:
        assert property (ar_take && ar_idx == `BTH_IDX_CLASS
            |=> rvalid_r && rdata_r == 32'h0006_0400)
        else $error("class code read wrong");

    a_line_size_store:
        assert property (wr_lane0 && aw_idx_r == `BTH_IDX_LINE_SZ
            |=> line_size_r == $past(w_data_r[7:0]))
        else $error("cache line size not stored");

    a_up_lat_zero:
        assert property (ar_take && ar_idx == `BTH_IDX_UP_LAT
            |=> rdata_r == 32'h0000_0000)
        else $error("upstream latency timer not zero");

    a_header_type:
        assert property (ar_take && ar_idx == `BTH_IDX_LAYOUT
            |=> rdata_r == 32'h0000_0001)
        else $error("header type not one");

    a_selftest_zero:
        assert property (ar_take && ar_idx == `BTH_IDX_SELFTEST
            |=> rdata_r == 32'h0000_0000)
        else $error("self test byte not zero");

    a_windows_zero:
        assert property (ar_take && (ar_idx == `BTH_IDX_WIN0
            || ar_idx == `BTH_IDX_WIN1) |=> rdata_r == 32'h0000_0000)
        else $error("address window not zero");

    a_up_bus_store:
        assert property (wr_lane0 && aw_idx_r == `BTH_IDX_UP_BUS
            |=> up_bus_r == $past(w_data_r[7:0]))
        else $error("upstream bus number not stored");

    a_dn_bus_hold:
        assert property (!(wr_lane0 && aw_idx_r == `BTH_IDX_DN_BUS)
            |=> $stable(dn_bus_r))
        else $error("downstream bus number changed");

    a_hi_bus_read:
        assert property (ar_take && ar_idx == `BTH_IDX_HI_BUS
            |=> rdata_r[7:0] == $past(hi_bus_r) && rdata_r[31:8] == 0)
        else $error("highest bus number read wrong");

    a_dn_lat_zero:
        assert property (ar_take && ar_idx == `BTH_IDX_DN_LAT
            |=> rdata_r == 32'h0000_0000)
        else $error("downstream latency timer not zero");

    a_io_low_read:
        assert property (ar_take && ar_idx == `BTH_IDX_IO_LOW
            |=> rdata_r[3:0] == 4'h1 && rdata_r[7:4] == $past(io_base_r))
        else $error("io window low read wrong");

    a_io_base_store:
        assert property (wr_lane0 && aw_idx_r == `BTH_IDX_IO_LOW
            |=> io_base_r == $past(w_data_r[7:4]))
        else $error("io base field not stored");

    a_fwd_decode:
        assert property (io_req_valid |=> io_fwd_valid && io_fwd_hit ==
            ($past(io_req_addr[31:16]) == 16'h0000
            && $past(io_req_addr[15:12]) >= $past(io_base_r)
            && $past(io_req_addr[15:12]) <= $past(io_limit_r)))
        else $error("io forwarding decision wrong");

    a_limit_cap_mirror:
        assert property (ar_take && ar_idx == `BTH_IDX_IO_HIGH
            |=> rdata_r[0] == $past(io_cap_r) && rdata_r[3:1] == 3'b000)
        else $error("limit capability bit differs");

    a_limit_top_hit:
        assert property (io_req_valid && io_req_addr[31:16] == 16'h0000
            && io_req_addr[15:12] == io_limit_r
            && io_base_r <= io_limit_r |=> io_fwd_hit)
        else $error("top of window not forwarded");

    a_ro_write_ignored:
        assert property (wr_fire && !(aw_idx_r inside {`BTH_IDX_LINE_SZ,
            `BTH_IDX_UP_BUS, `BTH_IDX_DN_BUS, `BTH_IDX_HI_BUS,
            `BTH_IDX_IO_LOW, `BTH_IDX_IO_HIGH})
            |=> $stable(line_size_r) && $stable(up_bus_r)
            && $stable(dn_bus_r) && $stable(hi_bus_r)
            && $stable(io_base_r) && $stable(io_limit_r) && io_cap_r)
        else $error("read-only write changed stored state");

    a_write_answer:
        assert property (wr_fire |=> s_axi_bvalid [*1] ##0
            s_axi_bresp == ($past(reg_mapped(aw_idx_r)) ? 2'b00 : 2'b10))
        else $error("write response wrong");

    a_read_hold:
        assert property (rvalid_r && !s_axi_rready
            |=> rvalid_r && $stable(rdata_r))
        else $error("read data dropped before taken");

    c_write_done:  cover property (wr_fire ##1 b_done);
    c_read_done:   cover property (ar_take ##[1:4] r_done);
    c_unmapped_rd: cover property (ar_take && !reg_mapped(ar_idx));
    c_fwd_hit:     cover property (io_fwd_hit);

endmodule

`default_nettype wire

// file: verif/tb_bth_cfg_regs.sv
// Self-checking bench for the bridge header register bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
        end \
    end

module tb_bth_cfg_regs;
    import bth_pkg::*;

    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        io_req_valid;
    logic [31:0] io_req_addr;
    logic        io_fwd_valid;
    logic        io_fwd_hit;
    int          n_errors;
    int          checks;
    int          cycles;

    bth_cfg_regs bth_cfg_regs_inst (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awprot  (3'b000),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arprot  (3'b000),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .io_req_valid  (io_req_valid),
        .io_req_addr   (io_req_addr),
        .io_fwd_valid  (io_fwd_valid),
        .io_fwd_hit    (io_fwd_hit)
    );

    // Clock of 5 ns period
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    // Reset held for four cycles, then two idle cycles
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    // Write with address and data offered together
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
                `CHK(s_axi_bresp, er)
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // Read and compare data and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
                `CHK(s_axi_rdata, ed)
                `CHK(s_axi_rresp, er)
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // Back-to-back classify requests; answer seen two edges after launch
    task automatic io_seq(input logic [31:0] a[$], input logic h[$]);
        int n;
        n = a.size();
        for (int k = 0; k < n + 3; k++) begin
            @(posedge aclk);
            if (k >= 2 && k < n + 2) begin
                `CHK(io_fwd_valid, 1'b1)
                `CHK(io_fwd_hit, h[k-2])
            end
            if (k == n + 2) `CHK(io_fwd_valid, 1'b0)
            io_req_valid <= (k < n);
            io_req_addr  <= (k < n) ? a[k] : 32'h0000_0000;
        end
    endtask

    task automatic t_reset_vals();
        rd_chk(8'h24, 32'h0006_0400, 2'b00); // bridge class
        rd_chk(8'h30, 32'h0000_0000, 2'b00); // line size zero
        rd_chk(8'h34, 32'h0000_0000, 2'b00); // timer zero
        rd_chk(8'h38, 32'h0000_0001, 2'b00); // type one
        rd_chk(8'h3C, 32'h0000_0000, 2'b00); // no self-test
        rd_chk(8'h40, 32'h0000_0000, 2'b00); // window zero
        rd_chk(8'h50, 32'h0000_0000, 2'b00); // window one
        rd_chk(8'h60, 32'h0000_0000, 2'b00); // upstream zero
        rd_chk(8'h64, 32'h0000_0000, 2'b00); // downstream zero
        rd_chk(8'h68, 32'h0000_0000, 2'b00); // highest zero
        rd_chk(8'h6C, 32'h0000_0000, 2'b00); // timer zero
        rd_chk(8'h70, 32'h0000_00F1, 2'b00); // base reset
        rd_chk(8'h74, 32'h0000_0001, 2'b00); // limit mirror bit
        $display("test reset_vals done");
    endtask

    task automatic t_rw_store();
        wr_chk(8'h30, 32'h1234_56A5, 4'h1, 2'b00);
        wr_chk(8'h60, 32'hFFFF_FF5A, 4'h1, 2'b00);
        wr_chk(8'h64, 32'h0000_0080, 4'hF, 2'b00);
        wr_chk(8'h68, 32'h0000_00FF, 4'h1, 2'b00);
        wr_chk(8'h64, 32'h0000_0011, 4'h0, 2'b00);
        rd_chk(8'h30, 32'h0000_00A5, 2'b00); // line size stored
        rd_chk(8'h60, 32'h0000_005A, 2'b00); // upstream stored
        rd_chk(8'h64, 32'h0000_0080, 2'b00); // no strobe kept
        rd_chk(8'h68, 32'h0000_00FF, 2'b00); // highest stored
        $display("test rw_store done");
    endtask

    task automatic t_ro_ignore();
        logic [7:0]  ad[7];
        logic [31:0] ex[7];
        ad = '{8'h24, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h50, 8'h6C};
        ex = '{32'h0006_0400, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            wr_chk(ad[i], 32'hFFFF_FFFF, 4'hF, 2'b00);
            rd_chk(ad[i], ex[i], 2'b00); // fixed after write
        end
        wr_chk(8'h70, 32'hFFFF_FFFF, 4'hF, 2'b00);
        rd_chk(8'h70, 32'h0000_00F1, 2'b00); // reserved zero
        wr_chk(8'h70, 32'h0000_0000, 4'hF, 2'b00);
        rd_chk(8'h70, 32'h0000_0001, 2'b00); // width bit held
        wr_chk(8'h74, 32'h0000_00FE, 4'h1, 2'b00);
        rd_chk(8'h74, 32'h0000_00F1, 2'b00); // mirror bit kept
        $display("test ro_ignore done");
    endtask

    task automatic t_unmapped();
        wr_chk(8'h00, 32'h0000_00FF, 4'hF, 2'b10);
        wr_chk(8'h44, 32'h0000_00FF, 4'hF, 2'b10);
        rd_chk(8'h44, 32'h0000_0000, 2'b10); // unmapped read
        rd_chk(8'h78, 32'h0000_0000, 2'b10); // past the bank
        rd_chk(8'h30, 32'h0000_00A5, 2'b00); // left untouched
        $display("test unmapped done");
    endtask

    task automatic t_io_window();
        wr_chk(8'h70, 32'h0000_0020, 4'h1, 2'b00);
        wr_chk(8'h74, 32'h0000_0040, 4'h1, 2'b00);
        rd_chk(8'h70, 32'h0000_0021, 2'b00); // base field
        rd_chk(8'h74, 32'h0000_0041, 2'b00); // limit field
        io_seq('{32'h0000_1FFF, 32'h0000_2000, 32'h0000_3ABC,
                 32'h0000_4FFF, 32'h0000_5000, 32'h0001_2000},
               '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0});
        wr_chk(8'h74, 32'h0000_0020, 4'h1, 2'b00);
        io_seq('{32'h0000_2000, 32'h0000_2FFF, 32'h0000_3000},
               '{1'b1, 1'b1, 1'b0}); // one page
        $display("test io_window done");
    endtask

    task automatic t_io_idle();
        io_seq('{32'h0000_0000, 32'h0000_0FFF, 32'h0000_F000,
                 32'h0000_FFFF},
               '{1'b0, 1'b0, 1'b0, 1'b0}); // empty window
        $display("test io_idle done");
    endtask

    // Main sequence
    initial begin
        n_errors      = 0;
        checks        = 0;
        cycles        = 0;
        aresetn       = 1'b0;
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0000_0000;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        io_req_valid  = 1'b0;
        io_req_addr   = 32'h0000_0000;
        do_reset();
        t_reset_vals();
        t_io_idle();
        t_rw_store();
        t_ro_ignore();
        t_unmapped();
        t_io_window();
        do_reset();
        t_reset_vals();
        t_io_idle();
        end_sim();
    end

endmodule

`default_nettype wire
